// ### dfc_pkg.sv
// Purpose: Shared constants, types and the frame checksum for the converter front end
// Assumes: 32-bit serial frames, 14-bit converter code, 125 MHz system clock
// Notes: Register addresses are five-bit frame addresses

package dfc_pkg;

	// ======================================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned LATCH_SETTLE_NS = 40;
	localparam int unsigned LATCH_SETTLE_CYC = (LATCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] LATCH_SETTLE_LOAD = 4'(LATCH_SETTLE_CYC);

	// ======================================================================
	// Frame geometry
	localparam logic [5:0] CNT_SHORT = 6'h18;
	localparam logic [5:0] CNT_FULL = 6'h20;
	localparam logic [5:0] CNT_MAX = 6'h3F;
	localparam logic [1:0] SYNC_PATTERN = 2'h2;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	// ======================================================================
	// Pin vector positions
	localparam int PIN_SCLK = 0;
	localparam int PIN_SEL_N = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_LOAD_N = 3;
	localparam int PIN_ADDR0 = 4;
	localparam int PIN_ADDR1 = 5;
	localparam int PIN_W = 6;

	// ======================================================================
	// Register addresses
	localparam logic [4:0] REG_NOP = 5'h00;
	localparam logic [4:0] REG_INPUT_CODE = 5'h01;
	localparam logic [4:0] REG_APPLIED_CODE = 5'h02;
	localparam logic [4:0] REG_GAIN_TRIM = 5'h03;
	localparam logic [4:0] REG_OFFSET_TRIM = 5'h04;
	localparam logic [4:0] REG_SW_LOAD = 5'h05;
	localparam logic [4:0] REG_RB_SELECT = 5'h06;
	localparam logic [4:0] REG_CHECK_CONFIG = 5'h07;
	localparam logic [4:0] REG_FAULT_FLAGS = 5'h08;
	localparam logic [4:0] REG_GENERAL_CONFIG_TWO = 5'h09;
	localparam logic [4:0] REG_STATUS = 5'h0A;

	// ======================================================================
	// Reset values
	localparam logic [15:0] GAIN_TRIM_RST = 16'hFFFC;
	localparam logic [15:0] OFFSET_TRIM_RST = 16'h8000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] CHECK_CONFIG_RST = 16'h0003;

	// ======================================================================
	// Field positions
	localparam int CFG_CRC_EN = 0;
	localparam int CFG_INVERSE_EN = 1;
	localparam int CFG_LATCH_MON_EN = 2;
	localparam int FLG_CRC = 0;
	localparam int FLG_SLIP = 1;
	localparam int FLG_COUNT = 2;
	localparam int FLG_LATCH = 3;
	localparam int FLG_W = 4;
	localparam int GC2_GLOBAL_LOAD = 0;
	localparam int STAT_FAULT = 0;
	localparam int STAT_PENDING = 1;
	localparam int RBS_ADDR_MSB = 4;
	localparam int RBS_MODE_LSB = 5;
	localparam int RBS_MODE_MSB = 6;
	localparam logic [1:0] RB_TWO_STAGE = 2'h0;
	localparam logic [1:0] RB_AUTOSTATUS = 2'h1;
	localparam logic [1:0] RB_ECHO = 2'h2;

	// ======================================================================
	// Code arithmetic
	localparam logic [13:0] CODE_MAX = 14'h3FFF;
	localparam logic [13:0] CODE_MIN = 14'h0000;
	localparam logic [16:0] HALF_SCALE = 17'h02000;

	// ======================================================================
	// Frame receiver states, Gray along idle-shift-evaluate
	typedef enum logic [1:0] {
		DFC_IDLE = 2'h0,
		DFC_SHIFT = 2'h1,
		DFC_EVAL = 2'h3
	} dfc_frame_state_t;

	// CRC-8, MSB first, over 24 bits
	function automatic logic [7:0] dfc_crc8(input logic [23:0] d);
		logic [7:0] c;
		logic fb;
		c = CRC_INIT;
		for (int i = 23; i >= 0; i--)
		begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

endpackage

// ### dfc_calc_if.sv
// Purpose: Carries the trim operands and the calibrated result between modules
// Assumes: All codes are 14-bit straight binary
// Notes: Purely combinational path

`timescale 1ns/1ps

interface dfc_calc_if;
	logic [13:0] input_code;
	logic [13:0] gain_code;
	logic [13:0] offset_code;
	logic [13:0] cal_code;
	modport user (output input_code, output gain_code, output offset_code, input cal_code);
	modport calc (input input_code, input gain_code, input offset_code, output cal_code);
endinterface

// ### dfc_code_calc.sv
// Purpose: Gain multiplier and offset adder producing the converter code
// Assumes: Operands held stable by the caller
// Notes: Result clamps at both ends of the 14-bit range

`timescale 1ns/1ps

module dfc_code_calc (
	dfc_calc_if.calc cif
);
	logic [14:0] gain_plus;
	logic [28:0] product;
	logic [16:0] sum;

	// =====================================================================
	// Arithmetic
	// input times gain plus one over 2^14, plus offset minus 2^13
	assign gain_plus = {1'b0, cif.gain_code} + 15'h0001;
	assign product = {15'h0000, cif.input_code} * {14'h0000, gain_plus};
	assign sum = {2'h0, product[28:14]} + {3'h0, cif.offset_code} - dfc_pkg::HALF_SCALE;

	// Clamp: a borrow out shows as bit 16, overflow as bits 15:14
	always_comb
	begin
		if (sum[16])
			cif.cal_code = dfc_pkg::CODE_MIN;
		else if (sum[15:14] != 2'h0)
			cif.cal_code = dfc_pkg::CODE_MAX;
		else
			cif.cal_code = sum[13:0];
	end
endmodule

// ### dfc_top.sv
// Purpose: Serial frame checking, register file, readback and code load path
// Assumes: Serial pins are asynchronous to mclk_in and far slower than it
// Notes: Slew engine lives outside; it feeds its intermediate code in

`timescale 1ns/1ps

// Function
// - Top frame bit must complement the next; else discard and flag slip error.
// - Checksum on: only exactly 32 falling clock edges make a valid write.
// - Checksum off: 24 or 32 falling clock edges make a valid write.
// - Other lengths are ignored and set a sticky clock-count error flag.
// - Select register names a register, next no-op frame shifts it out.
// - Readback: 10 sync, fault bit, address, sixteen data bits, checksum.
// - Autostatus mode, off at reset, returns status on every frame.
// - Echo mode alternates status with a copy of the last command.
// - Gain trim straight binary, reset 0xFFFC gives unity, factor (M+1)/16384.
// - Offset trim straight binary, reset 0x8000 means zero offset.
// - Code equals input times (gain+1) over 2^14 plus offset minus 2^13.
// - Trim writes do not change output; next input write applies them.
// - Read-only register holds loaded code before the trims.
// - Load strobe low: input write updates output at frame end.
// - Load strobe high: update waits for software load or strobe pulse.
// - While slewing, applied-code register follows the intermediate value.
// - Global load mode lets software load ignore device address bits.
// - Complemented code copy must match before strobing; enabled by default.
// - Latch monitor compares latched and internal code, sets sticky flag.
// - Frames arrive MSB first, sampled on falling serial clock edges.
// - Frame accepted only if its device address equals the address pins, or if it is a software load in global load mode.
// - CRC-8 x^8+x^2+x+1 over 24 bits, on by default, failures discarded.
module dfc_top (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Serial port
	input wire logic sclk_in,
	input wire logic frame_sel_n_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_out,
	// Load strobe and board address
	input wire logic load_strobe_n_in,
	input wire logic board_address_pin_zero_in,
	input wire logic board_address_pin_one_in,
	// Converter side
	output logic [13:0] calibrated_code_out,
	output logic dac_strobe_out,
	input wire logic [13:0] latch_code_in,
	// Slew engine
	input wire logic slew_active_in,
	input wire logic [15:0] slew_code_in
);
	dfc_pkg::dfc_frame_state_t state;
	logic [dfc_pkg::PIN_W-1:0] pin_a;
	logic [dfc_pkg::PIN_W-1:0] pin_b;
	logic [13:0] latch_a;
	logic [13:0] latch_b;
	logic sclk_prev;
	logic sel_prev;
	logic load_prev;
	logic sclk_fall;
	logic sclk_rise;
	logic sel_fall;
	logic sel_rise;
	logic load_fall;
	logic [5:0] bit_cnt;
	logic [31:0] rx_shift;
	logic [31:0] tx_shift;
	logic [23:0] word;
	logic in_eval;
	logic crc_en;
	logic len_ok;
	logic slip_ok;
	logic crc_ok;
	logic addr_ok;
	logic accept;
	logic [4:0] reg_addr;
	logic [15:0] wdata;
	logic [15:0] gain_trim;
	logic [15:0] offset_trim;
	logic [15:0] input_code;
	logic [15:0] applied_code;
	logic [15:0] rb_select;
	logic [15:0] check_config;
	logic [15:0] general_config_two;
	logic [dfc_pkg::FLG_W-1:0] flags;
	logic [dfc_pkg::FLG_W-1:0] flag_set;
	logic [dfc_pkg::FLG_W-1:0] flag_clr;
	logic [23:0] last_cmd;
	logic echo_phase;
	logic pending;
	logic [13:0] pend_code;
	logic [13:0] pend_inv;
	logic [15:0] pend_input;
	logic sw_load_wr;
	logic load_go;
	logic inv_ok;
	logic apply;
	logic capture;
	logic [3:0] settle;
	logic fault;
	logic [15:0] status;
	logic [4:0] rb_addr;
	logic [15:0] rb_data;
	logic [23:0] rb_head;
	logic [31:0] next_tx;

	dfc_calc_if cal_if ();

	dfc_code_calc u_calc (
		.cif(cal_if.calc)
	);

	// ======================================================================
	// Input synchronisers
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_a <= 6'h0B;
			pin_b <= 6'h0B;
			latch_a <= 14'h0000;
			latch_b <= 14'h0000;
		end
		else
		begin
			pin_a <= {board_address_pin_one_in, board_address_pin_zero_in, load_strobe_n_in,
				sdi_in, frame_sel_n_in, sclk_in};
			pin_b <= pin_a;
			latch_a <= latch_code_in;
			latch_b <= latch_a;
		end
	end

	// Edge history, taken only from the second stage
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sclk_prev <= 1'b1;
			sel_prev <= 1'b1;
			load_prev <= 1'b1;
		end
		else
		begin
			sclk_prev <= pin_b[dfc_pkg::PIN_SCLK];
			sel_prev <= pin_b[dfc_pkg::PIN_SEL_N];
			load_prev <= pin_b[dfc_pkg::PIN_LOAD_N];
		end
	end

	assign sclk_fall = sclk_prev & ~pin_b[dfc_pkg::PIN_SCLK];
	assign sclk_rise = ~sclk_prev & pin_b[dfc_pkg::PIN_SCLK];
	assign sel_fall = sel_prev & ~pin_b[dfc_pkg::PIN_SEL_N];
	assign sel_rise = ~sel_prev & pin_b[dfc_pkg::PIN_SEL_N];
	assign load_fall = load_prev & ~pin_b[dfc_pkg::PIN_LOAD_N];

	// ======================================================================
	// Frame receiver
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			state <= dfc_pkg::DFC_IDLE;
		else
		begin
			case (state)
				dfc_pkg::DFC_IDLE:
					if (sel_fall)
						state <= dfc_pkg::DFC_SHIFT;
				dfc_pkg::DFC_SHIFT:
					if (sel_rise)
						state <= dfc_pkg::DFC_EVAL;
				dfc_pkg::DFC_EVAL:
					state <= dfc_pkg::DFC_IDLE;
				default:
					state <= dfc_pkg::DFC_IDLE;
			endcase
		end
	end

	// Count saturates so that a runaway frame never wraps back to a legal length
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			bit_cnt <= 6'h00;
			rx_shift <= 32'h00000000;
		end
		else if (state == dfc_pkg::DFC_IDLE && sel_fall)
			bit_cnt <= 6'h00;
		// MSB first, sampled on falling serial clock
		else if (state == dfc_pkg::DFC_SHIFT && sclk_fall)
		begin
			rx_shift <= {rx_shift[30:0], pin_b[dfc_pkg::PIN_SDI]};
			if (bit_cnt != dfc_pkg::CNT_MAX)
				bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// ======================================================================
	// Frame checks
	assign in_eval = (state == dfc_pkg::DFC_EVAL);
	assign crc_en = check_config[dfc_pkg::CFG_CRC_EN];
	assign word = (bit_cnt == dfc_pkg::CNT_SHORT) ? rx_shift[23:0] : rx_shift[31:8];
	assign reg_addr = word[20:16];
	assign wdata = word[15:0];
	// allowed lengths depend on the checksum enable
	assign len_ok = crc_en ? (bit_cnt == dfc_pkg::CNT_FULL) :
		(bit_cnt == dfc_pkg::CNT_FULL || bit_cnt == dfc_pkg::CNT_SHORT);
	// slip bit is the complement of the bit below
	assign slip_ok = word[23] ^ word[22];
	// checksum over the 24 data bits
	assign crc_ok = ~crc_en || (dfc_pkg::dfc_crc8(word) == rx_shift[7:0]);
	// device address must match the pins, except global load
	assign addr_ok = (word[22:21] == {pin_b[dfc_pkg::PIN_ADDR1], pin_b[dfc_pkg::PIN_ADDR0]}) ||
		(general_config_two[dfc_pkg::GC2_GLOBAL_LOAD] && reg_addr == dfc_pkg::REG_SW_LOAD);
	assign accept = in_eval & len_ok & slip_ok & crc_ok & addr_ok;
	assign sw_load_wr = accept && reg_addr == dfc_pkg::REG_SW_LOAD;

	// ======================================================================
	// Register file
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// trims reset to unity gain and zero offset
			gain_trim <= dfc_pkg::GAIN_TRIM_RST;
			offset_trim <= dfc_pkg::OFFSET_TRIM_RST;
			input_code <= dfc_pkg::ZERO16;
			rb_select <= dfc_pkg::ZERO16;
			check_config <= dfc_pkg::CHECK_CONFIG_RST;
			general_config_two <= dfc_pkg::ZERO16;
			last_cmd <= 24'h000000;
		end
		else if (accept)
		begin
			last_cmd <= word;
			case (reg_addr)
				dfc_pkg::REG_INPUT_CODE: input_code <= wdata;
				dfc_pkg::REG_GAIN_TRIM: gain_trim <= wdata;
				dfc_pkg::REG_OFFSET_TRIM: offset_trim <= wdata;
				// select the register for the next frame
				dfc_pkg::REG_RB_SELECT: rb_select <= wdata;
				dfc_pkg::REG_CHECK_CONFIG: check_config <= wdata;
				dfc_pkg::REG_GENERAL_CONFIG_TWO: general_config_two <= wdata;
				default: ;
			endcase
		end
	end

	// Sticky fault flags, write one to clear; a new event wins over its clear
	// error events
	assign flag_set[dfc_pkg::FLG_COUNT] = in_eval & ~len_ok;
	assign flag_set[dfc_pkg::FLG_SLIP] = in_eval & len_ok & ~slip_ok;
	assign flag_set[dfc_pkg::FLG_CRC] = in_eval & len_ok & slip_ok & ~crc_ok;
	assign flag_set[dfc_pkg::FLG_LATCH] = check_config[dfc_pkg::CFG_LATCH_MON_EN] &&
		settle == 4'h0 && latch_b != calibrated_code_out;
	assign flag_clr = (accept && reg_addr == dfc_pkg::REG_FAULT_FLAGS) ?
		wdata[dfc_pkg::FLG_W-1:0] : 4'h0;

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			flags <= 4'h0;
		else
			flags <= (flags & ~flag_clr) | flag_set;
	end

	// ======================================================================
	// Code calculation and load path
	// trims feed the multiplier but only an input write latches its result
	assign cal_if.input_code = input_code[15:2];
	assign cal_if.gain_code = gain_trim[15:2];
	assign cal_if.offset_code = offset_trim[15:2];

	// strobe low loads at once, high waits for a load request
	assign load_go = pending & (~pin_b[dfc_pkg::PIN_LOAD_N] | load_fall | sw_load_wr);
	// complemented copy must match before the converter is strobed
	assign inv_ok = ~check_config[dfc_pkg::CFG_INVERSE_EN] || (pend_code == ~pend_inv);
	assign apply = load_go & inv_ok;

	// Capture comes one cycle after the input write, once the multiplier sees it;
	// a repeated input code still picks up freshly written trims
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			capture <= 1'b0;
		else
			capture <= accept && reg_addr == dfc_pkg::REG_INPUT_CODE;
	end

	// Pending code; a fresh capture wins over an apply of the older code
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pending <= 1'b0;
			pend_code <= 14'h0000;
			pend_inv <= 14'h3FFF;
			pend_input <= dfc_pkg::ZERO16;
		end
		else if (capture)
		begin
			pending <= 1'b1;
			pend_code <= cal_if.cal_code;
			pend_inv <= ~cal_if.cal_code;
			pend_input <= input_code;
		end
		// a failed copy check leaves the request pending
		else if (apply)
			pending <= 1'b0;
	end

	// Converter code and strobe
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			calibrated_code_out <= 14'h0000;
			dac_strobe_out <= 1'b0;
		end
		else
		begin
			dac_strobe_out <= apply;
			if (apply)
				calibrated_code_out <= pend_code;
		end
	end

	// Applied code before trims
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			applied_code <= dfc_pkg::ZERO16;
		else if (slew_active_in)
			applied_code <= slew_code_in;
		// untrimmed copy of the loaded code
		else if (apply)
			applied_code <= pend_input;
	end

	// Latches need time to follow a new code before the monitor compares
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			settle <= dfc_pkg::LATCH_SETTLE_LOAD;
		else if (apply)
			settle <= dfc_pkg::LATCH_SETTLE_LOAD;
		else if (settle != 4'h0)
			settle <= settle - 4'h1;
	end

	// ======================================================================
	// Readback
	assign fault = |flags;
	assign status = {14'h0000, pending, fault};

	always_comb
	begin
		case (rb_addr)
			dfc_pkg::REG_INPUT_CODE: rb_data = input_code;
			dfc_pkg::REG_APPLIED_CODE: rb_data = applied_code;
			dfc_pkg::REG_GAIN_TRIM: rb_data = gain_trim;
			dfc_pkg::REG_OFFSET_TRIM: rb_data = offset_trim;
			dfc_pkg::REG_RB_SELECT: rb_data = rb_select;
			dfc_pkg::REG_CHECK_CONFIG: rb_data = check_config;
			dfc_pkg::REG_FAULT_FLAGS: rb_data = {12'h000, flags};
			dfc_pkg::REG_GENERAL_CONFIG_TWO: rb_data = general_config_two;
			dfc_pkg::REG_STATUS: rb_data = status;
			default: rb_data = dfc_pkg::ZERO16;
		endcase
	end

	// autostatus and echo override the selection
	always_comb
	begin
		case (rb_select[dfc_pkg::RBS_MODE_MSB:dfc_pkg::RBS_MODE_LSB])
			dfc_pkg::RB_AUTOSTATUS: rb_addr = dfc_pkg::REG_STATUS;
			dfc_pkg::RB_ECHO: rb_addr = echo_phase ? last_cmd[20:16] : dfc_pkg::REG_STATUS;
			default: rb_addr = rb_select[dfc_pkg::RBS_ADDR_MSB:0];
		endcase
		// sync pattern, fault, address, data, checksum
		if (rb_select[dfc_pkg::RBS_MODE_MSB:dfc_pkg::RBS_MODE_LSB] == dfc_pkg::RB_ECHO &&
			echo_phase)
			rb_head = {dfc_pkg::SYNC_PATTERN, fault, last_cmd[20:0]};
		else
			rb_head = {dfc_pkg::SYNC_PATTERN, fault, rb_addr, rb_data};
		next_tx = {rb_head, dfc_pkg::dfc_crc8(rb_head)};
	end

	// Echo alternates on every frame start
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			echo_phase <= 1'b0;
		else if (state == dfc_pkg::DFC_IDLE && sel_fall)
			echo_phase <= (rb_select[dfc_pkg::RBS_MODE_MSB:dfc_pkg::RBS_MODE_LSB] ==
				dfc_pkg::RB_ECHO) ? ~echo_phase : 1'b0;
	end

	// Output shifter moves on rising serial clock so the host samples a settled bit
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			tx_shift <= 32'h00000000;
		else if (state == dfc_pkg::DFC_IDLE && sel_fall)
			tx_shift <= next_tx;
		else if (state == dfc_pkg::DFC_SHIFT && sclk_rise)
			tx_shift <= {tx_shift[30:0], 1'b0};
	end

	assign sdo_out = tx_shift[31];
	assign sdo_oe_out = (state == dfc_pkg::DFC_SHIFT);

	// ======================================================================
	// Assertions
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_slip_discard: assert property (in_eval && len_ok && !slip_ok |=>
		flags[dfc_pkg::FLG_SLIP] && $stable(input_code) && $stable(gain_trim))
		else $error("slip error frame not discarded");
	a_count_strict: assert property (in_eval && crc_en && bit_cnt != dfc_pkg::CNT_FULL |=>
		flags[dfc_pkg::FLG_COUNT] && $stable(gain_trim))
		else $error("bad length accepted with checksum on");
	a_short_frame: assert property (in_eval && !crc_en && bit_cnt == dfc_pkg::CNT_SHORT &&
		slip_ok && addr_ok && reg_addr == dfc_pkg::REG_INPUT_CODE |=> input_code == $past(wdata))
		else $error("short frame write lost");
	a_count_flag: assert property (in_eval && bit_cnt != dfc_pkg::CNT_FULL &&
		(crc_en || bit_cnt != dfc_pkg::CNT_SHORT) |=> flags[dfc_pkg::FLG_COUNT])
		else $error("count error not flagged");
	a_crc_reject: assert property (in_eval && len_ok && slip_ok && !crc_ok |=>
		flags[dfc_pkg::FLG_CRC] && $stable(input_code))
		else $error("checksum failure not rejected");
	a_addr_filter: assert property (in_eval && reg_addr == dfc_pkg::REG_INPUT_CODE &&
		word[22:21] != {pin_b[dfc_pkg::PIN_ADDR1], pin_b[dfc_pkg::PIN_ADDR0]}
		|=> $stable(input_code))
		else $error("foreign address accepted");
	a_sync_header: assert property (state == dfc_pkg::DFC_IDLE && sel_fall |=>
		tx_shift[31:30] == dfc_pkg::SYNC_PATTERN && tx_shift[29] == $past(fault))
		else $error("readback header wrong");
	a_auto_status: assert property (rb_select[dfc_pkg::RBS_MODE_MSB:dfc_pkg::RBS_MODE_LSB] ==
		dfc_pkg::RB_AUTOSTATUS && state == dfc_pkg::DFC_IDLE && sel_fall |=>
		tx_shift[28:24] == dfc_pkg::REG_STATUS)
		else $error("autostatus did not return status");
	a_trim_hold: assert property (accept && reg_addr == dfc_pkg::REG_GAIN_TRIM && !pending
		|=> $stable(calibrated_code_out) [*2])
		else $error("trim write changed output");
	a_hw_load: assert property (accept && reg_addr == dfc_pkg::REG_INPUT_CODE &&
		!pin_b[dfc_pkg::PIN_LOAD_N] ##1 !pin_b[dfc_pkg::PIN_LOAD_N] ##1
		(!pin_b[dfc_pkg::PIN_LOAD_N] && inv_ok) |=> dac_strobe_out)
		else $error("output not updated with strobe low");
	a_load_defer: assert property (pending && pin_b[dfc_pkg::PIN_LOAD_N] && !load_fall &&
		!sw_load_wr |=> !dac_strobe_out)
		else $error("output updated without load");
	a_latch_flag: assert property (check_config[dfc_pkg::CFG_LATCH_MON_EN] && settle == 4'h0 &&
		latch_b != calibrated_code_out |=> flags[dfc_pkg::FLG_LATCH])
		else $error("latch mismatch not flagged");

	c_input_write: cover property (accept && reg_addr == dfc_pkg::REG_INPUT_CODE);
	c_crc_fail: cover property (flag_set[dfc_pkg::FLG_CRC]);
	c_sw_load: cover property (sw_load_wr && pending ##1 dac_strobe_out);
	c_echo_frame: cover property (echo_phase && state == dfc_pkg::DFC_IDLE && sel_fall);
endmodule

// ### dfc_host_model.sv
// Purpose: Host serial master that shifts frames in and captures the answer
// Assumes: Link clock 125 ns, idle high, device samples on falling edges
// Notes: Free-running delays keep the link unrelated in phase to mclk_in
`timescale 1ns/1ps
module dfc_host_model (
	// Sampling clock and answer line
	input wire logic mclk_in,
	input wire logic sdo_in,
	// Serial outputs
	output logic sclk_out,
	output logic sel_n_out,
	output logic sdi_out
);
	logic [31:0] rx_word;
	event done;
	// Idle levels at time zero
	initial
	begin
		sclk_out = 1'b1;
		sel_n_out = 1'b1;
		sdi_out = 1'b0;
	end
	// Gap of several cycles between frames keeps the select spacing legal
	task automatic send(input logic [31:0] w, input int n);
		repeat (6) @(posedge mclk_in);
		sel_n_out = 1'b0;
		#100;
		for (int i = 31; i > 31 - n; i--)
		begin
			sdi_out = w[i];
			#31 sclk_out = 1'b0;
			rx_word = {rx_word[30:0], sdo_in};
			#62.5 sclk_out = 1'b1;
			#31.5;
		end
		#50 sel_n_out = 1'b1;
		sdi_out = ~sdi_out; // Released line must not keep its last value
		->done;
	endtask
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the converter front end
// Assumes: Host model drives the link; results checked from queues
// Notes: Any strobe with no queued expectation counts as a mismatch
`timescale 1ns/1ps
module tb_top;
	logic mclk_in, rst_in = 1'b1, load_n = 1'b0, sclk, sel_n, sdi, sdo, strobe, slew = 1'b0;
	logic [15:0] scode = 16'h0000;
	logic [13:0] code;
	logic [1:0] dev = 2'h1;
	logic [15:0] gain = dfc_pkg::GAIN_TRIM_RST, offs = dfc_pkg::OFFSET_TRIM_RST, d;
	logic [31:0] f;
	logic [13:0] exp_code[$];
	logic [31:0] exp_rb[$];
	logic [20:0] rs[3] = '{{dfc_pkg::REG_GAIN_TRIM, dfc_pkg::GAIN_TRIM_RST},
		{dfc_pkg::REG_OFFSET_TRIM, dfc_pkg::OFFSET_TRIM_RST},
		{dfc_pkg::REG_CHECK_CONFIG, dfc_pkg::CHECK_CONFIG_RST}};
	logic [15:0] fl[3] = '{16'h0002, 16'h0001, 16'h0004};
	int err_count = 0, total_checks = 0, seed = 15777;
	dfc_host_model u_dfc_host_model (.mclk_in(mclk_in), .sdo_in(sdo), .sclk_out(sclk),
		.sel_n_out(sel_n), .sdi_out(sdi));
	dfc_top u_dfc_top (.mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk),
		.frame_sel_n_in(sel_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(),
		.load_strobe_n_in(load_n), .board_address_pin_zero_in(dev[0]),
		.board_address_pin_one_in(dev[1]), .calibrated_code_out(code),
		.dac_strobe_out(strobe), .latch_code_in(code), .slew_active_in(slew),
		.slew_code_in(scode));
	// Checksum, frame builder and trimmed code, all from first principles
	function automatic logic [7:0] crc(input logic [23:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	function automatic logic [31:0] frm(input logic [1:0] a, input logic [4:0] r, input logic [15:0] v);
		return {~a[1], a, r, v, crc({~a[1], a, r, v})};
	endfunction
	function automatic logic [13:0] cal(input logic [15:0] x);
		int v;
		v = int'(x[15:2]) * (int'(gain[15:2]) + 1) / 16384 + int'(offs[15:2]) - 8192;
		return (v < 0) ? 14'h0000 : (v > 16383) ? 14'h3FFF : 14'(v);
	endfunction
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] r, input logic [15:0] v);
		u_dfc_host_model.send(frm(dev, r, v), 32);
	endtask
	task automatic wi(input logic [15:0] v, input logic e);
		if (e)
			exp_code.push_back(cal(v));
		wr(dfc_pkg::REG_INPUT_CODE, v);
	endtask
	task automatic rd(input logic [15:0] s, input logic [4:0] a, input logic [15:0] v, input logic x);
		wr(dfc_pkg::REG_RB_SELECT, s);
		@(posedge mclk_in);
		exp_rb.push_back({2'h2, x, a, v, crc({2'h2, x, a, v})});
		wr(dfc_pkg::REG_NOP, 16'h0000);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Clock, watchdog and result watchers
	initial
	begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end
	initial
	begin
		#500000 err_count++;
		wrap_up();
	end
	always @(negedge mclk_in)
		if (strobe === 1'b1)
			cmp("code", exp_code.size() ? 32'(exp_code.pop_front()) : 32'hFFFFFFFF, 32'(code));
	always @(u_dfc_host_model.done)
		if (exp_rb.size())
			cmp("readback", exp_rb.pop_front(), u_dfc_host_model.rx_word);
	// Main sequence
	initial
	begin
		repeat (6) @(posedge mclk_in);
		rst_in <= 1'b0;
		foreach (rs[i]) rd(16'(rs[i][20:16]), rs[i][20:16], rs[i][15:0], 1'b0);
		d = $random(seed) & 16'hFFFC;
		wi(d, 1'b1);
		rd(16'(dfc_pkg::REG_APPLIED_CODE), dfc_pkg::REG_APPLIED_CODE, d, 1'b0);
		repeat (3)
		begin
			gain = $random(seed) & 16'hFFFC;
			offs = $random(seed) & 16'hFFFC;
			wr(dfc_pkg::REG_GAIN_TRIM, gain);
			wr(dfc_pkg::REG_OFFSET_TRIM, offs);
			wi($random(seed) & 16'hFFFC, 1'b1);
		end
		for (int i = 0; i < 3; i++)
		begin
			f = frm(dev, dfc_pkg::REG_INPUT_CODE, 16'h1234);
			u_dfc_host_model.send(i == 0 ? f ^ 32'h80000000 : i == 1 ? f ^ 32'h1 : f, i == 2 ? 24 : 32);
			rd(16'(dfc_pkg::REG_FAULT_FLAGS), dfc_pkg::REG_FAULT_FLAGS, fl[i], 1'b1);
			wr(dfc_pkg::REG_FAULT_FLAGS, 16'h000F);
		end
		u_dfc_host_model.send(frm(~dev, dfc_pkg::REG_INPUT_CODE, 16'h4444), 32);
		wr(dfc_pkg::REG_CHECK_CONFIG, 16'h0002);
		d = $random(seed) & 16'hFFFC;
		exp_code.push_back(cal(d));
		u_dfc_host_model.send(frm(dev, dfc_pkg::REG_INPUT_CODE, d), 24);
		wr(dfc_pkg::REG_CHECK_CONFIG, 16'h0003);
		@(posedge mclk_in) load_n <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			wr(dfc_pkg::REG_GENERAL_CONFIG_TWO, 16'(i));
			d = $random(seed) & 16'hFFFC;
			wi(d, 1'b0);
			repeat (20) @(posedge mclk_in);
			exp_code.push_back(cal(d));
			u_dfc_host_model.send(frm(i ? ~dev : dev, dfc_pkg::REG_SW_LOAD, 16'h0000), 32);
		end
		d = $random(seed) & 16'hFFFC;
		wi(d, 1'b0);
		repeat (20) @(posedge mclk_in);
		exp_code.push_back(cal(d));
		load_n <= 1'b0;
		repeat (4) @(posedge mclk_in);
		load_n <= 1'b1;
		d = $random(seed);
		@(posedge mclk_in) {slew, scode} <= {1'b1, d};
		rd(16'(dfc_pkg::REG_APPLIED_CODE), dfc_pkg::REG_APPLIED_CODE, d, 1'b0);
		@(posedge mclk_in) slew <= 1'b0;
		rd(16'h0020, dfc_pkg::REG_STATUS, 16'h0000, 1'b0);
		rd(16'h0040, dfc_pkg::REG_STATUS, 16'h0000, 1'b0);
		f = {2'h2, 1'b0, dfc_pkg::REG_NOP, 16'h0000, 8'h00};
		exp_rb.push_back({f[31:8], crc(f[31:8])});
		wr(dfc_pkg::REG_NOP, 16'h0000);
		repeat (20) @(posedge mclk_in);
		cmp("pending codes", 32'h0, 32'(exp_code.size()));
		wrap_up();
	end
endmodule
